// ### verilog/eqt_tuning_bank.sv
`timescale 1ns/1ps
`include "eqt_defs.svh"
// How it works
// R1: the coarse launch bit resets to 0 for a full launch, and writing 1 selects the attenuated input setting.
// R2: the four-bit fine launch field resets to 0000 and its code is handed to the gain stage as written.
// R3: the host writes zeros into the three low reserved bits of the launch register.
// R4: the cable length register is read-only, with the length in bits 7:3 and zeros below.
// R5: the bypass pin routes the signal around the adaptive stage while high.
// R6: in pin mode the auto-sleep pin, when high, powers the device down whenever no signal is present.
// R7: the no-carrier output goes high with no input, so tying it to the mute pin mutes the output.
// R8: a mute reference level mutes the output once signal degradation reaches it.
// R9: a write frame is a 0, seven address bits and eight data bits on rising edges, output left undriven.
// R10: a read frame is a 1 and seven address bits, then eight data bits shift out from the 8th falling edge.
// R11: the serial-mode pin high enables register access, low leaves control to the pins alone.
// R12: the revision register always returns the fixed code and ignores writes.
module eqt_tuning_bank #(
  parameter logic [7:0] REV_CODE = 8'h5A        // arbitrary value
) (
  input  wire logic       MCLK_IN,              // 40 MHz clock
  input  wire logic       RST_N_IN,             // async reset, active low
  input  wire logic       SPI_MODE_IN,          // serial-mode select pin
  input  wire logic       SCK_IN,               // serial clock pin
  input  wire logic       SS_N_IN,              // select pin, active low
  input  wire logic       MOSI_IN,              // serial data in
  output logic            MISO_OUT,             // serial data out
  output logic            MISO_OE_OUT,          // high while MISO is driven
  input  wire logic       BYPASS_IN,            // bypass pin
  input  wire logic       AUTO_SLEEP_IN,        // auto-sleep select pin
  input  wire logic       MUTE_IN,              // output mute pin
  input  wire logic       SIGNAL_PRESENT_IN,    // input detector level
  input  wire logic [4:0] CABLE_LEN_IN,         // measured cable length
  input  wire logic [4:0] DEGRADE_IN,           // measured signal degradation
  input  wire logic [4:0] MUTE_REF_IN,          // mute reference, zero disables
  output logic            NO_CARRIER_OUT,       // high while no input signal
  output logic            EQ_BYPASS_OUT,        // route around equaliser
  output logic            POWER_DOWN_OUT,       // power the device down
  output logic            OUT_MUTE_OUT,         // mute the output driver
  output logic            COARSE_LAUNCH_OUT,    // attenuated launch setting
  output logic [3:0]      FINE_LAUNCH_OUT       // fine gain code
);
  logic [`EQT_SYNC_W-1:0] pin_s1;
  logic [`EQT_SYNC_W-1:0] pin_s2;
  logic [4:0]             launch;

  eqt_bus_if bus ();

  // every pin passes two flops; pin_s1 feeds pin_s2 only
  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
    end else begin
      pin_s1 <= {DEGRADE_IN, CABLE_LEN_IN, SPI_MODE_IN, SIGNAL_PRESENT_IN,
                 MUTE_IN, AUTO_SLEEP_IN, BYPASS_IN};
      pin_s2 <= pin_s1;
    end
  end

  // synchronised pin levels
  wire       bypass_s   = pin_s2[0];
  wire       sleep_s    = pin_s2[1];
  wire       mute_s     = pin_s2[2];
  wire       signal_s   = pin_s2[3];
  wire       spi_mode_s = pin_s2[4];
  wire [4:0] cable_s    = pin_s2[9:5];
  wire [4:0] degrade_s  = pin_s2[14:10];

  eqt_spi_shift u_shift (
    .clk     (MCLK_IN),
    .rst_n   (RST_N_IN),
    .sck     (SCK_IN),
    .ss_n    (SS_N_IN),
    .mosi    (MOSI_IN),
    .enable  (spi_mode_s),                     // pin mode blocks all access [R11]
    .miso    (MISO_OUT),
    .miso_oe (MISO_OE_OUT),
    .bus     (bus.shifter)
  );

  // the mute reference pins pass two flops like every other pin
  logic [4:0]  mute_ref_s1;
  logic [4:0]  mute_ref_s2;
  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      mute_ref_s1 <= 5'h00;
      mute_ref_s2 <= 5'h00;
    end else begin
      mute_ref_s1 <= MUTE_REF_IN;
      mute_ref_s2 <= mute_ref_s1;
    end
  end

  // multi-bit levels are taken only after two equal samples in a row, so a word
  // caught half-changed never reaches the read mux or the mute compare
  logic [14:0] word_last;
  logic [14:0] word_held;
  wire  [14:0] word_now   = {mute_ref_s2, degrade_s, cable_s};
  wire         word_match = word_now == word_last;
  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      word_last <= '0;
      word_held <= '0;
    end else begin
      word_last <= word_now;
      if (word_match) begin
        word_held <= word_now;
      end
    end
  end
  wire  [4:0]  cable_h    = word_held[4:0];
  wire  [4:0]  degrade_h  = word_held[9:5];
  wire  [4:0]  mute_ref_h = word_held[14:10];

  // register decode on the address the shifter presents
  wire hit_launch = bus.addr == `EQT_ADDR_LAUNCH;
  wire hit_cable  = bus.addr == `EQT_ADDR_CABLE;
  wire hit_rev    = bus.addr == `EQT_ADDR_REV;
  wire launch_we  = bus.wr_stb & hit_launch;   // revision address has no write path [R12]

  // read mux; reserved low bits read zero whatever the host wrote [R3]
  assign bus.rdata = hit_launch ? {launch, `EQT_RSVD_LOW} :
                     hit_cable  ? {cable_h, `EQT_RSVD_LOW} :   // [R4]
                     hit_rev    ? REV_CODE :                   // [R12]
                                  `EQT_UNMAPPED_DATA;

  // launch register; only bits 7:3 are stored
  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      launch <= `EQT_LAUNCH_RST;                               // [R1] [R2]
    end else if (launch_we) begin
      launch <= bus.wdata[`EQT_WDATA_TOP_MSB:`EQT_WDATA_TOP_LSB];  // [R1] [R2]
    end
  end

  // degradation threshold on the settled words; a zero reference turns it off
  wire degrade_mute = (mute_ref_h != 5'h00) && (degrade_h >= mute_ref_h);   // [R8]

  // control outputs; in pin mode the launch stage stays at nominal
  wire next_power_down = sleep_s & ~signal_s & ~spi_mode_s;  // [R6] [R11]
  wire next_mute       = mute_s | degrade_mute;               // [R7] [R8]
  wire next_coarse     = spi_mode_s & launch[`EQT_COARSE_BIT];
  wire [3:0] next_fine = spi_mode_s ? launch[`EQT_FINE_MSB:0] : 4'h0;

  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      NO_CARRIER_OUT    <= 1'b1;
      EQ_BYPASS_OUT     <= 1'b0;
      POWER_DOWN_OUT    <= 1'b0;
      OUT_MUTE_OUT      <= 1'b0;
      COARSE_LAUNCH_OUT <= 1'b0;
      FINE_LAUNCH_OUT   <= 4'h0;
    end else begin
      NO_CARRIER_OUT    <= ~signal_s;          // [R7]
      EQ_BYPASS_OUT     <= bypass_s;           // [R5]
      POWER_DOWN_OUT    <= next_power_down;    // [R6]
      OUT_MUTE_OUT      <= next_mute;          // [R7] [R8]
      COARSE_LAUNCH_OUT <= next_coarse;        // [R1]
      FINE_LAUNCH_OUT   <= next_fine;          // [R2]
    end
  end

  // a launch write reaches the coarse output two cycles later in serial mode
  coarse_write_a: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN) // [R1]
    (launch_we && spi_mode_s) ##1 spi_mode_s |=> COARSE_LAUNCH_OUT == $past(bus.wdata[7], 2))
    else $error("coarse launch output does not follow write");

  // fine code follows the write the same way
  fine_write_a: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN) // [R2]
    (launch_we && spi_mode_s) ##1 spi_mode_s |=> FINE_LAUNCH_OUT == $past(bus.wdata[6:3], 2))
    else $error("fine launch output does not follow write");

  // cable length reads with zero low bits
  cable_read_a: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN) // [R4]
    (bus.rd_stb && hit_cable) |-> bus.rdata == {cable_h, 3'h0})
    else $error("cable length read wrong");

  // bypass output tracks the pin through three flops
  bypass_path_a: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN) // [R5]
    $rose(BYPASS_IN) ##1 BYPASS_IN [*3] |-> EQ_BYPASS_OUT)
    else $error("bypass output late");

  // auto sleep powers down only without signal in pin mode
  sleep_power_a: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN) // [R6]
    POWER_DOWN_OUT |-> $past(sleep_s) && !$past(signal_s) && !$past(spi_mode_s))
    else $error("power down without cause");

  // no carrier mutes when the two pins are joined
  carrier_mute_a: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN) // [R7]
    mute_s |=> OUT_MUTE_OUT)
    else $error("mute pin ignored");

  // degradation at the reference mutes the output
  degrade_mute_a: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN) // [R8]
    degrade_mute |=> OUT_MUTE_OUT)
    else $error("degradation mute missing");

  // revision reads the fixed code
  rev_read_a: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN) // [R12]
    (bus.rd_stb && hit_rev) |-> bus.rdata == REV_CODE)
    else $error("revision read wrong");

  // pin mode keeps the launch stage nominal
  pin_mode_a: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN) // [R11]
    !spi_mode_s |=> !COARSE_LAUNCH_OUT && FINE_LAUNCH_OUT == 4'h0)
    else $error("launch setting active in pin mode");

  // a write to a read-only or unmapped address leaves the launch register alone
  ro_write_a: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN) // [R12]
    (bus.wr_stb && !hit_launch) |=> $stable(launch))
    else $error("read-only write changed the launch register");

  // a present signal clears the no-carrier output
  carrier_clear_a: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN) // [R7]
    signal_s |=> !NO_CARRIER_OUT)
    else $error("no-carrier output high with signal present");

  // no power down without auto sleep, with signal present, or in serial mode
  sleep_off_a: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN) // [R6]
    (!sleep_s || signal_s || spi_mode_s) |=> !POWER_DOWN_OUT)
    else $error("power down without cause");

  // no mute without the mute pin or degradation at or past the reference
  mute_off_a: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN) // [R8]
    (!mute_s && !degrade_mute) |=> !OUT_MUTE_OUT)
    else $error("output muted without cause");
endmodule

// ### verilog/eqt_defs.svh
`ifndef EQT_DEFS_SVH
`define EQT_DEFS_SVH

// register addresses on the serial port
`define EQT_ADDR_LAUNCH   7'h02
`define EQT_ADDR_CABLE    7'h03
`define EQT_ADDR_REV      7'h04

// launch amplitude register layout
`define EQT_LAUNCH_RST    5'h00
`define EQT_COARSE_BIT    4
`define EQT_FINE_MSB      3
`define EQT_WDATA_TOP_MSB 7
`define EQT_WDATA_TOP_LSB 3
`define EQT_RSVD_LOW      3'h0
`define EQT_UNMAPPED_DATA 8'h00

// serial frame bit counts
`define EQT_CNT_ZERO      5'h00
`define EQT_CNT_ONE       5'h01
`define EQT_CMD_LAST      5'h07
`define EQT_FRAME_LAST    5'h0F
`define EQT_CNT_FIRST_DAT 5'h08

// pin synchroniser width
`define EQT_SYNC_W        15

`endif

// ### verilog/eqt_pkg.sv
package eqt_pkg;
  // serial frame phase
  typedef enum logic [1:0] {
    EQT_PH_ADDR,
    EQT_PH_WDATA,
    EQT_PH_RDATA,
    EQT_PH_DONE
  } eqt_phase_t;
endpackage

// ### verilog/eqt_bus_if.sv
`timescale 1ns/1ps
// register access strobes between the serial shifter and the register bank
interface eqt_bus_if;
  logic       wr_stb;
  logic       rd_stb;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport shifter (output wr_stb, output rd_stb, output addr, output wdata, input rdata);
  modport bank    (input wr_stb, input rd_stb, input addr, input wdata, output rdata);
endinterface

// ### verilog/eqt_spi_shift.sv
`timescale 1ns/1ps
`include "eqt_defs.svh"
module eqt_spi_shift (
  input  wire logic    clk,       // system clock
  input  wire logic    rst_n,     // async reset, active low
  input  wire logic    sck,       // serial clock pin, raw
  input  wire logic    ss_n,      // select pin, raw, active low
  input  wire logic    mosi,      // serial data in, raw
  input  wire logic    enable,    // serial mode, already synchronised
  output logic         miso,      // serial data out
  output logic         miso_oe,   // high while miso is driven
  eqt_bus_if.shifter   bus        // register strobes
);
  logic [2:0]          sync1;
  logic [2:0]          sync2;
  logic                sck_d;
  logic [14:0]         shin;
  logic [4:0]          cnt;
  logic [7:0]          shout;
  eqt_pkg::eqt_phase_t phase;

  // two-flop synchronisers; only sync2 is looked at by logic
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // reset to the idle pins (select high, clock low) so no false edge follows
      sync1 <= 3'h2;
      sync2 <= 3'h2;
      sck_d <= 1'b0;
    end else begin
      sync1 <= {mosi, ss_n, sck};
      sync2 <= sync1;
      sck_d <= sync2[0];
    end
  end

  // edge and frame decode
  wire       sck_rise = sync2[0] & ~sck_d;
  wire       sck_fall = ~sync2[0] & sck_d;
  wire       mosi_s   = sync2[2];
  wire       sel      = ~sync2[1] & enable;
  wire [7:0] first8   = {shin[6:0], mosi_s};
  wire       at_cmd   = sel & sck_rise & (phase == eqt_pkg::EQT_PH_ADDR) & (cnt == `EQT_CMD_LAST);
  wire       at_end   = sel & sck_rise & (phase == eqt_pkg::EQT_PH_WDATA)
                        & (cnt == `EQT_FRAME_LAST);

  assign bus.rd_stb = at_cmd & first8[7];          // [R10]
  assign bus.wr_stb = at_end;                      // [R9]
  assign bus.addr   = at_cmd ? first8[6:0] : shin[13:7];
  assign bus.wdata  = first8;

  // frame engine: bits in on rising sck, read data out on falling sck
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase   <= eqt_pkg::EQT_PH_ADDR;
      cnt     <= `EQT_CNT_ZERO;
      shin    <= 15'h0000;
      shout   <= 8'h00;
      miso    <= 1'b0;
      miso_oe <= 1'b0;
    end else if (!sel) begin
      phase   <= eqt_pkg::EQT_PH_ADDR;
      cnt     <= `EQT_CNT_ZERO;
      miso_oe <= 1'b0;                             // released outside a frame [R9]
    end else begin
      if (sck_rise && phase != eqt_pkg::EQT_PH_DONE) begin
        shin <= {shin[13:0], mosi_s};
        cnt  <= 5'(cnt + `EQT_CNT_ONE);
      end
      if (bus.rd_stb) begin
        shout <= bus.rdata;                        // fetch right after 8th rise [R10]
      end
      unique case (phase)
        eqt_pkg::EQT_PH_ADDR: begin
          if (at_cmd) begin
            phase <= first8[7] ? eqt_pkg::EQT_PH_RDATA : eqt_pkg::EQT_PH_WDATA;
          end
        end
        eqt_pkg::EQT_PH_WDATA: begin
          if (at_end) begin
            phase <= eqt_pkg::EQT_PH_DONE;         // extra clocks ignored
          end
        end
        eqt_pkg::EQT_PH_RDATA: begin
          if (sck_fall && cnt >= `EQT_CNT_FIRST_DAT) begin
            miso_oe <= 1'b1;                       // drive from 8th falling edge [R10]
            miso    <= shout[7];
            shout   <= {shout[6:0], 1'b0};
          end
        end
        eqt_pkg::EQT_PH_DONE: begin
        end
      endcase
    end
  end

  // a write frame never turns the data output on
  wr_quiet_a: assert property (@(posedge clk) disable iff (!rst_n) // [R9]
    (phase == eqt_pkg::EQT_PH_WDATA) |-> !miso_oe)
    else $error("data output driven during write frame");

  // the fetch lands in the output shifter while the data line is still off
  rd_cmd_a: assert property (@(posedge clk) disable iff (!rst_n) // [R10]
    bus.rd_stb |=> (shout == $past(bus.rdata)) && !miso_oe)
    else $error("read fetch lost or output driven early");

  // deselect releases the output within a cycle
  sel_release_a: assert property (@(posedge clk) disable iff (!rst_n) // [R9]
    !sel |=> !miso_oe)
    else $error("data output kept driven after deselect");
endmodule

// ### bench/eqt_host_model.sv
`timescale 1ns/1ps
// serial host: drives select, clock and data off the falling system clock edge
module eqt_host_model (
  input  wire logic clk,     // system clock
  input  wire logic miso,    // data from the bank
  input  wire logic miso_oe, // high while the bank drives
  output logic      sck,     // serial clock, still outside frames
  output logic      ss_n,    // select, active low
  output logic      mosi     // data to the bank
);
  // six clocks a phase keeps well above the four the oversampler needs
  localparam int HALF = 6;
  initial begin
    sck  = 1'h0;
    ss_n = 1'h1;
    mosi = 1'h0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk);
  endtask
  // one frame, msb first; fewer than 16 bits aborts it by raising select
  task automatic xfer(input logic [7:0] head, input logic [7:0] data, input int nbits,
                      output logic [7:0] rdata, output logic oe_seen);
    logic [15:0] word;
    word    = {head, data};
    rdata   = 'x;
    oe_seen = 1'h0;
    ss_n    = 1'h0;
    wait_clk(HALF);
    for (int i = 0; i < nbits; i++) begin
      // released line after the 8th rise: a busy pattern, not a held value
      if (head[7] && i >= 8) mosi = ~mosi;
      else mosi = word[15 - i];
      sck = 1'h0;
      wait_clk(HALF);
      if (i >= 8) begin
        oe_seen = oe_seen | miso_oe;
        if (miso_oe === 1'h1) rdata[15 - i] = miso;
      end
      sck = 1'h1;
      wait_clk(HALF);
    end
    sck = 1'h0;
    wait_clk(HALF);
    ss_n = 1'h1;
    wait_clk(HALF);
  endtask
endmodule

// ### bench/testbench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD %0t mismatch got %h exp %h", $time, g, e); end end
module testbench;
  localparam logic [7:0] REV = 8'hC3; // arbitrary value
  // ctl is spi, bypass, sleep, mute, tie, signal; exp is carrier, bypass, down, mute
  typedef struct packed {
    logic [5:0] ctl;
    logic [4:0] deg;
    logic [4:0] mref;
    logic [3:0] exp;
  } eqt_pin_row_t;
  logic         mclk, rst_n, spi_mode, byp, slp, mute_drv, tie, sig;
  logic [4:0]   cab, deg, mref;
  logic         sck, ss_n, mosi, miso, miso_oe, nc, ebyp, pd, om, coarse, mute, oe;
  logic [3:0]   fine;
  logic [7:0]   r;
  int           n_mismatch = 0;
  int           num_checks = 0;
  eqt_pin_row_t rows [10];
  // carrier output strapped to the mute pin when tie is set
  assign mute = tie ? nc : mute_drv;
  initial begin
    mclk = 1'h0;
    forever #12.5 mclk = ~mclk;
  end
  eqt_tuning_bank #(.REV_CODE(REV)) i_dut (
    .MCLK_IN(mclk), .RST_N_IN(rst_n), .SPI_MODE_IN(spi_mode), .SCK_IN(sck),
    .SS_N_IN(ss_n), .MOSI_IN(mosi), .MISO_OUT(miso), .MISO_OE_OUT(miso_oe),
    .BYPASS_IN(byp), .AUTO_SLEEP_IN(slp), .MUTE_IN(mute), .SIGNAL_PRESENT_IN(sig),
    .CABLE_LEN_IN(cab), .DEGRADE_IN(deg), .MUTE_REF_IN(mref), .NO_CARRIER_OUT(nc),
    .EQ_BYPASS_OUT(ebyp), .POWER_DOWN_OUT(pd), .OUT_MUTE_OUT(om),
    .COARSE_LAUNCH_OUT(coarse), .FINE_LAUNCH_OUT(fine));
  eqt_host_model i_host (.clk(mclk), .miso(miso), .miso_oe(miso_oe), .sck(sck),
    .ss_n(ss_n), .mosi(mosi));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d, input int n);
    i_host.xfer({1'h0, a}, d, n, r, oe);
    `CHK(oe, 1'h0)
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e, input logic eo);
    i_host.xfer({1'h1, a}, 8'h00, 16, r, oe);
    `CHK(oe, eo)
    if (eo) `CHK(r, e)
  endtask
  // about 80 frames of some 210 clocks each, so this leaves ample margin
  initial begin
    repeat (40000) @(posedge mclk);
    n_mismatch++;
    give_verdict();
  end
  initial begin
    {spi_mode, byp, slp, mute_drv, tie, sig} = 6'h01;
    {cab, deg, mref} = {5'h19, 5'h00, 5'h00};
    rst_n = 1'h0;
    rows = '{{6'h01, 5'h00, 5'h00, 4'h0}, {6'h11, 5'h00, 5'h00, 4'h4},
             {6'h08, 5'h00, 5'h00, 4'hA}, {6'h09, 5'h00, 5'h00, 4'h0},
             {6'h28, 5'h00, 5'h00, 4'h8}, {6'h05, 5'h00, 5'h00, 4'h1},
             {6'h01, 5'h09, 5'h0A, 4'h0}, {6'h01, 5'h0A, 5'h0A, 4'h1},
             {6'h01, 5'h1F, 5'h00, 4'h0}, {6'h02, 5'h00, 5'h00, 4'h9}};
    repeat (2) @(negedge mclk);
    `CHK({nc, miso_oe, coarse, fine}, 7'h40)
    rst_n = 1'h1;
    repeat (4) @(negedge mclk);
    $display("reset test done");
    // pin level cases, eight clocks covers sync plus the output register
    foreach (rows[i]) begin
      {spi_mode, byp, slp, mute_drv, tie, sig} = rows[i].ctl;
      {deg, mref} = {rows[i].deg, rows[i].mref};
      repeat (8) @(negedge mclk);
      `CHK(nc, rows[i].exp[3])
      `CHK(ebyp, rows[i].exp[2])
      `CHK(pd, rows[i].exp[1])
      `CHK(om, rows[i].exp[0])
    end
    $display("pin test done");
    {spi_mode, byp, slp, mute_drv, tie, sig} = 6'h21;
    {deg, mref} = 10'h000;
    repeat (4) @(negedge mclk);
    rd(7'h02, 8'h00, 1'h1);
    // every coarse and fine code, read back with the low bits zero
    for (int k = 0; k < 32; k++) begin
      wr(7'h02, {k[4:0], 3'h0}, 16);
      repeat (4) @(negedge mclk);
      `CHK({coarse, fine}, k[4:0])
      rd(7'h02, {k[4:0], 3'h0}, 1'h1);
    end
    wr(7'h02, 8'h00, 10);
    rd(7'h02, 8'hF8, 1'h1);
    wr(7'h03, 8'h00, 16);
    wr(7'h04, 8'h00, 16);
    wr(7'h05, 8'h00, 16);
    rd(7'h03, {5'h19, 3'h0}, 1'h1);
    rd(7'h04, REV, 1'h1);
    rd(7'h7F, 8'h00, 1'h1);
    `CHK({coarse, fine}, 5'h1F)
    $display("register test done");
    spi_mode = 1'h0;
    repeat (4) @(negedge mclk);
    `CHK({coarse, fine}, 5'h00)
    rd(7'h02, 8'h00, 1'h0);
    wr(7'h02, 8'h00, 16);
    spi_mode = 1'h1;
    repeat (4) @(negedge mclk);
    rd(7'h02, 8'hF8, 1'h1);
    $display("pin mode test done");
    rst_n = 1'h0;
    repeat (2) @(negedge mclk);
    rst_n = 1'h1;
    repeat (4) @(negedge mclk);
    rd(7'h02, 8'h00, 1'h1);
    $display("second reset test done");
    give_verdict();
  end
endmodule
